// file: acf_frame_ctrl.sv
`timescale 1ns/1ps

// Behaviour
// - Single: Hi-Z until first present edge, MSB first
// - Frame sync high at select fall: MSB then
// - Frame sync low: MSB at select fall/sync rise
// - Data changes on SCLK rising edges
// - Dual/differential: Hi-Z while select high
// - Hi-Z after the sixteenth SCLK
// - Sixteen-bit frame, result on top, four pad
// - Straight binary code passed unchanged
// - Control levels seen on SCLK falling edge
// - Select-only: select fall starts the cycle
// - Sync-only: sync rise presents, fall starts
// - Combined: select presents, sync fall starts
// - Dual/differential: only select fall starts
// - Four to seven SCLKs reset channel zero
// - More than seven SCLKs toggle channel
// - Sampling window twelve SCLKs from fourth fall
// - Convert after sixteenth fall, 28 SCLKs
// - Shifted data is previous cycle's result
// - Power down at end, wake on select fall or sync rise
// - Aborted conversion invalidates next data cycle
module acf_frame_ctrl #(
    parameter acf_pkg::acf_variant_t VARIANT = acf_pkg::VAR_SINGLE
) (
    input wire logic clk,
    input wire logic rst_n,
    input acf_pkg::acf_pins_t pins,
    input wire logic [11:0] sampleCode,
    output logic sdoOut,
    output logic sdoOe,
    output logic muxSelect,
    output logic powerUp,
    output logic sampleActive,
    output logic convActive,
    output logic dataValid
);

    localparam bit IS_SINGLE = (VARIANT == acf_pkg::VAR_SINGLE);
    localparam bit IS_DUAL = (VARIANT == acf_pkg::VAR_DUAL);

    acf_pkg::acf_pins_t pinSync;
    acf_pkg::acf_pins_t pinPrev_q;
    acf_pkg::acf_edges_t edges;
    acf_pkg::acf_state_t state_q;
    acf_pkg::acf_state_t state_d;

    logic [acf_pkg::FALL_W-1:0] fallCount_q;
    logic [acf_pkg::FRAME_BITS-1:0] shift_q;
    logic [11:0] result_q;
    logic [11:0] pending_q;
    logic [3:0] muxFalls_q;
    logic oe_q;
    logic armed_q;
    logic csOnlyMode_q;
    logic fsCycle_q;
    logic awake_q;
    logic stale_q;
    logic valid_q;
    logic mux_q;
    logic convBusy;
    logic convDone;

    // Pins come from the host's timing, so two flops before any use
    acf_sync #(
        .WIDTH(3),
        .RESET_VALUE(acf_pkg::PINS_IDLE)
    ) u_pin_sync (
        .clk(clk),
        .rst_n(rst_n),
        .asyncIn(pins),
        .syncOut(pinSync)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pinPrev_q <= acf_pkg::PINS_IDLE;
        end else begin
            pinPrev_q <= pinSync;
        end
    end

    wire csLow = !pinSync.chipSelectN;
    wire fsLvl = pinSync.frame_sync_in;
    assign edges.sclkRise = pinSync.sclk && !pinPrev_q.sclk;
    assign edges.sclkFall = !pinSync.sclk && pinPrev_q.sclk;
    assign edges.csFall = csLow && pinPrev_q.chipSelectN;
    assign edges.csRise = !csLow && !pinPrev_q.chipSelectN;
    assign edges.fsRise = IS_SINGLE && fsLvl && !pinPrev_q.frame_sync_in;
    assign edges.fsFall = IS_SINGLE && !fsLvl && pinPrev_q.frame_sync_in;

    // start gating
    // A select-fall start only counts once a falling SCLK saw select high; a sync-fall start needs no arming
    wire armedNow = armed_q || (edges.sclkFall && !csLow);

    // select starts
    // Select fall starts when sync is high, and always on two-pin parts
    wire csStart = edges.csFall && armedNow && (!IS_SINGLE || fsLvl);
    wire fsStart = edges.fsFall && csLow && !csOnlyMode_q;
    wire startEvt = (csStart || fsStart) && (state_q == acf_pkg::ST_SLEEP);

    // present MSB
    // Select fall always drives the MSB; sync rise drives it only while select is low and the output is off
    wire presentEvt = edges.csFall || (edges.fsRise && csLow && !oe_q);

    // Frame ends on select rise, or sync rise for a sync-driven cycle
    wire endEvt = edges.csRise || (fsCycle_q && edges.fsRise);
    wire abortEvt = endEvt && (state_q == acf_pkg::ST_CONVERT);

    wire inFrame = (state_q == acf_pkg::ST_FRAME);
    wire lastFall = inFrame && edges.sclkFall &&
        (fallCount_q == acf_pkg::CONV_START_FALLS - 5'h01);
    wire shiftEvt = inFrame && edges.sclkRise && (fallCount_q != 5'h00) &&
        (fallCount_q < acf_pkg::CONV_START_FALLS);
    wire hizEvt = edges.sclkRise && (fallCount_q >= acf_pkg::CONV_START_FALLS);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            acf_pkg::ST_SLEEP: begin
                if (startEvt) begin
                    state_d = acf_pkg::ST_FRAME;
                end
            end
            acf_pkg::ST_FRAME: begin
                if (endEvt) begin
                    state_d = acf_pkg::ST_SLEEP;
                end else if (lastFall) begin
                    state_d = acf_pkg::ST_CONVERT;
                end
            end
            acf_pkg::ST_CONVERT: begin
                if (abortEvt || convDone) begin
                    state_d = acf_pkg::ST_SLEEP;
                end
            end
            default: begin
                state_d = acf_pkg::ST_SLEEP;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= acf_pkg::ST_SLEEP;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            armed_q <= 1'b0;
            csOnlyMode_q <= 1'b0;
            fsCycle_q <= 1'b0;
        end else begin
            armed_q <= startEvt ? 1'b0 : armedNow;
            if (edges.csFall) begin
                csOnlyMode_q <= fsLvl;
            end else if (edges.csRise) begin
                csOnlyMode_q <= 1'b0;
            end
            if (startEvt) begin
                fsCycle_q <= fsStart;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fallCount_q <= 5'h00;
        end else if (startEvt) begin
            fallCount_q <= 5'h00;
        end else if (edges.sclkFall && fallCount_q != acf_pkg::FALL_SAT) begin
            fallCount_q <= fallCount_q + 5'h01;
        end
    end

    assign sampleActive = inFrame && (fallCount_q >= acf_pkg::SAMPLE_OPEN_FALLS);

    acf_conv_timer #(
        .CW(acf_pkg::CONV_W),
        .LENGTH(acf_pkg::CONV_SCLKS)
    ) u_conv (
        .clk(clk),
        .rst_n(rst_n),
        .start(lastFall && !endEvt),
        .tick(edges.sclkFall),
        .abort(abortEvt),
        .busy(convBusy),
        .done(convDone)
    );

    assign convActive = convBusy;

    // result pipeline
    // Sample held until conversion ends; frames always show the older word
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pending_q <= acf_pkg::RESULT_RESET;
            result_q <= acf_pkg::RESULT_RESET;
        end else begin
            if (lastFall) begin
                pending_q <= sampleCode;
            end
            if (convDone) begin
                result_q <= pending_q;
            end
        end
    end

    wire [acf_pkg::FRAME_BITS-1:0] frameWord = {result_q, acf_pkg::PAD_BITS};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_q <= '0;
        end else if (presentEvt) begin
            shift_q <= frameWord;
        end else if (shiftEvt) begin
            shift_q <= {shift_q[acf_pkg::FRAME_BITS-2:0], 1'b0};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            oe_q <= 1'b0;
        end else if (presentEvt) begin
            oe_q <= 1'b1;
        end else if (edges.csRise || hizEvt) begin
            oe_q <= 1'b0;
        end
    end

    assign sdoOut = shift_q[acf_pkg::FRAME_BITS-1];
    assign sdoOe = oe_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            awake_q <= 1'b0;
            stale_q <= 1'b0;
            valid_q <= 1'b0;
        end else begin
            if (edges.csFall || edges.fsRise) begin
                awake_q <= 1'b1;
            end else if (convDone) begin
                awake_q <= 1'b0;
            end
            if (abortEvt) begin
                stale_q <= 1'b1;
            end else if (presentEvt) begin
                stale_q <= 1'b0;
            end
            if (presentEvt) begin
                valid_q <= !stale_q && !abortEvt;
            end
        end
    end

    assign powerUp = awake_q;
    assign dataValid = valid_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            muxFalls_q <= 4'h0;
        end else if (edges.csFall) begin
            muxFalls_q <= 4'h0;
        end else if (csLow && edges.sclkFall && muxFalls_q != acf_pkg::MUX_FALL_SAT) begin
            muxFalls_q <= muxFalls_q + 4'h1;
        end
    end

    wire muxResetCyc = (muxFalls_q >= acf_pkg::MUX_RESET_MIN) &&
        (muxFalls_q <= acf_pkg::MUX_RESET_MAX);
    wire muxToggleCyc = muxFalls_q > acf_pkg::MUX_RESET_MAX;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mux_q <= acf_pkg::MUX_RESET_CHANNEL;
        end else if (IS_DUAL && edges.csRise && muxResetCyc) begin
            mux_q <= acf_pkg::MUX_RESET_CHANNEL;
        end else if (IS_DUAL && edges.csRise && muxToggleCyc) begin
            mux_q <= !mux_q;
        end
    end

    assign muxSelect = mux_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    chk_oe_cause: assert property ($rose(oe_q) |-> $past(presentEvt))
        else $error("Output enabled without a present edge");

    chk_msb_first: assert property (presentEvt |=> sdoOut == $past(result_q[11]))
        else $error("MSB not on output after present edge");

    chk_shift_rise: assert property (shiftEvt && !presentEvt |=>
        shift_q == {$past(shift_q[14:0]), 1'b0})
        else $error("Shift missed on SCLK rising edge");

    chk_data_hold: assert property (!edges.sclkRise && !presentEvt |=> $stable(sdoOut))
        else $error("Output data changed off a rising edge");

    chk_hiz_sixteen: assert property (hizEvt && !presentEvt |=> !sdoOe)
        else $error("Output not released after sixteenth SCLK");

    chk_hiz_cs_high: assert property (!IS_SINGLE && !csLow && pinPrev_q.chipSelectN |-> !sdoOe)
        else $error("Output driven while select high");

    chk_conv_enter: assert property (lastFall && !endEvt |=> state_q == acf_pkg::ST_CONVERT)
        else $error("Conversion did not start after sixteenth fall");

    chk_sample_open: assert property ($rose(sampleActive) |-> fallCount_q == 5'h04)
        else $error("Sampling window opened on wrong SCLK");

    chk_mux_reset: assert property (IS_DUAL && edges.csRise && muxResetCyc |=> !mux_q)
        else $error("Short select cycle did not reset channel");

    chk_mux_toggle: assert property (IS_DUAL && edges.csRise && muxToggleCyc |=>
        mux_q != $past(mux_q))
        else $error("Long select cycle did not toggle channel");

    chk_power_down: assert property (convDone && !(edges.csFall || edges.fsRise) |=> !awake_q)
        else $error("No power down after conversion");

    chk_result_prev: assert property (convDone |=> result_q == $past(pending_q))
        else $error("Result not taken from finished conversion");

    chk_stale_next: assert property (abortEvt |=> stale_q)
        else $error("Aborted conversion not marked stale");

endmodule : acf_frame_ctrl

// file: acf_pkg.sv
package acf_pkg;

    // Frame layout and result coding
    localparam int unsigned RESULT_BITS = 12;
    localparam int unsigned FRAME_BITS = 16;
    localparam logic [3:0] PAD_BITS = 4'h0;
    localparam logic [11:0] RESULT_RESET = 12'h000;

    // Counts of SCLK falling edges within one cycle
    localparam int unsigned FALL_W = 5;
    localparam logic [4:0] SAMPLE_OPEN_FALLS = 5'h04;
    localparam logic [4:0] CONV_START_FALLS = 5'h10;
    localparam logic [4:0] FALL_SAT = 5'h1F;
    localparam int unsigned CONV_W = 5;
    localparam logic [4:0] CONV_SCLKS = 5'h1C;

    // Active chip-select length that resets the channel multiplexer
    localparam logic [3:0] MUX_RESET_MIN = 4'h4;
    localparam logic [3:0] MUX_RESET_MAX = 4'h7;
    localparam logic [3:0] MUX_FALL_SAT = 4'hF;
    localparam logic MUX_RESET_CHANNEL = 1'b0;

    typedef enum logic [1:0] {
        VAR_SINGLE = 2'b00,
        VAR_DUAL = 2'b01,
        VAR_PSEUDO_DIFF = 2'b10
    } acf_variant_t;

    // Gray codes along sleep -> frame -> convert
    typedef enum logic [1:0] {
        ST_SLEEP = 2'b00,
        ST_FRAME = 2'b01,
        ST_CONVERT = 2'b11
    } acf_state_t;

    typedef struct packed {
        logic sclk;
        logic chipSelectN;
        logic frame_sync_in;
    } acf_pins_t;

    // Idle pin levels; sync and edge flops start here so reset shows no edge
    localparam acf_pins_t PINS_IDLE = '{sclk: 1'b0, chipSelectN: 1'b1, frame_sync_in: 1'b1};

    typedef struct packed {
        logic sclkRise;
        logic sclkFall;
        logic csFall;
        logic csRise;
        logic fsRise;
        logic fsFall;
    } acf_edges_t;

endpackage : acf_pkg

// file: acf_sync.sv
`timescale 1ns/1ps

module acf_sync #(
    parameter int unsigned WIDTH = 3,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= RESET_VALUE;
            syncOut <= RESET_VALUE;
        end else begin
            meta_q <= asyncIn;
            syncOut <= meta_q;
        end
    end

endmodule : acf_sync

// file: acf_conv_timer.sv
`timescale 1ns/1ps

module acf_conv_timer #(
    parameter int unsigned CW = acf_pkg::CONV_W,
    parameter logic [CW-1:0] LENGTH = acf_pkg::CONV_SCLKS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic tick,
    input wire logic abort,
    output logic busy,
    output logic done
);

    logic [CW-1:0] count_q;
    logic busy_q;
    wire lastTick = busy_q && tick && (count_q == LENGTH - CW'(1));

    assign busy = busy_q;
    assign done = lastTick && !abort;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
            count_q <= '0;
        end else if (start) begin
            busy_q <= 1'b1;
            count_q <= '0;
        end else if (abort || lastTick) begin
            busy_q <= 1'b0;
            count_q <= '0;
        end else if (busy_q && tick) begin
            count_q <= count_q + CW'(1);
        end
    end

endmodule : acf_conv_timer

// file: acf_host_model.sv
`timescale 1ns/1ps

// Host serial port: clock idles low, data taken on falling SCLK
// Clock polarity zero, phase one
module acf_host_model (
    input wire logic clk,
    input wire logic sdoWire,
    output acf_pkg::acf_pins_t pins
);
    localparam int HALF = 4;

    // Frame sync unused on this variant, so held high
    initial begin
        pins = '{sclk: 1'b0, chipSelectN: 1'b1, frame_sync_in: 1'b1};
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    // Select stays low for the whole cycle; caller picks the length
    // Select held through conversion only when falls reach 44
    task automatic frame(input int falls, output logic [15:0] bits);
        bits = 16'hxxxx;
        pins.chipSelectN = 1'b0;
        tick(HALF);
        for (int i = 0; i < falls; i++) begin
            pins.sclk = 1'b1;
            tick(HALF);
            if (i < 16) begin
                bits[15 - i] = sdoWire;
            end
            pins.sclk = 1'b0;
            tick(HALF);
        end
        tick(2);
    endtask : frame

    // One falling SCLK while select high
    task automatic end_cycle();
        pins.chipSelectN = 1'b1;
        tick(HALF);
        pins.sclk = 1'b1;
        tick(HALF);
        pins.sclk = 1'b0;
        tick(HALF + 2);
    endtask : end_cycle

endmodule : acf_host_model

// file: tb_top.sv
`timescale 1ns/1ps

`define CHECK(what, exp, got) begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
        badCount++; \
        $display("mismatch %s expected %h seen %h", what, exp, got); \
    end \
end

module tb_top;
    logic clk;
    logic rst_n;
    logic [11:0] sampleCode;
    acf_pkg::acf_pins_t pins;
    logic sdoOut;
    logic sdoOe;
    logic muxSelect;
    logic powerUp;
    logic sampleActive;
    logic convActive;
    logic dataValid;
    wire sdoWire = sdoOe ? sdoOut : 1'bz;
    int badCount = 0;
    int comparisons = 0;
    integer seed = 41;
    // Includes a reset-length cycle at each end of 4..7 and one abort
    int lens[12] = '{46, 46, 5, 46, 7, 4, 46, 20, 46, 3, 46, 46};

    acf_frame_ctrl #(
        .VARIANT(acf_pkg::VAR_DUAL)
    ) dut (
        .clk(clk),
        .rst_n(rst_n),
        .pins(pins),
        .sampleCode(sampleCode),
        .sdoOut(sdoOut),
        .sdoOe(sdoOe),
        .muxSelect(muxSelect),
        .powerUp(powerUp),
        .sampleActive(sampleActive),
        .convActive(convActive),
        .dataValid(dataValid)
    );

    acf_host_model host (
        .clk(clk),
        .sdoWire(sdoWire),
        .pins(pins)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic report_and_stop();
        if (badCount == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (20000) @(posedge clk);
        badCount++;
        report_and_stop();
    end

    initial begin
        logic [15:0] bits;
        logic [15:0] expWord;
        logic [11:0] code;
        // Finished results in order; a frame shows the newest one
        logic [11:0] doneQ[$];
        logic muxExp;
        int validExp;
        int n;
        rst_n = 1'b0;
        sampleCode = 12'h000;
        doneQ.push_back(acf_pkg::RESULT_RESET);
        muxExp = 1'b0;
        validExp = -1;
        repeat (16) @(posedge clk);
        #1;
        rst_n = 1'b1;
        host.tick(2);
        host.end_cycle();
        for (int c = 0; c < 12; c++) begin
            n = lens[c];
            code = 12'($random(seed));
            // End codes of the scale pass unchanged
            if (c == 0) code = 12'hFFF;
            if (c == 1) code = 12'h000;
            sampleCode = code;
            expWord = {doneQ[$], acf_pkg::PAD_BITS};
            host.frame(n, bits);
            for (int b = 0; b < 16 && b < n; b++) begin
                `CHECK("sdo bit", expWord[15 - b], bits[15 - b])
            end
            if (validExp >= 0) begin
                `CHECK("data valid", validExp[0], dataValid)
            end
            // Window from fourth fall to sixteenth
            `CHECK("sample window", (n >= 4 && n < 16), sampleActive)
            `CHECK("converting", (n >= 16 && n < 44), convActive)
            `CHECK("powered", (n < 44), powerUp)
            `CHECK("sdo enable", (n < 16), sdoOe)
            host.end_cycle();
            if (n >= 44) begin
                doneQ.push_back(code);
                validExp = 1;
            end else if (n >= 16) begin
                validExp = 0;
            end else begin
                validExp = -1;
            end
            // Short cycle clears, long one toggles
            if (n > 7) begin
                muxExp = ~muxExp;
            end else if (n >= 4) begin
                muxExp = 1'b0;
            end
            `CHECK("channel", muxExp, muxSelect)
            `CHECK("idle enable", 1'b0, sdoOe)
            // Only a finished conversion powers down; short or cut cycles stay awake
            `CHECK("idle power", (n < 44), powerUp)
        end
        report_and_stop();
    end

endmodule : tb_top
